// ---- rtl/dlf_latency_fetch.sv ----
// Memory latency fetch client over the firmware command mailbox.
//
// Contract
// - Poll pending clear, result 00h success.
// - First word holds levels 0 to 3.
// - Second word holds levels 4 to 7.
// - Equal neighbouring levels are accepted silently.
// - Scaling enabled after reset until disabled.
module dlf_latency_fetch (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Register port.
  input  wire logic [4:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // Mailbox master port.
  output logic      [1:0]           mbox_addr,
  output logic      [31:0]          mbox_wdata,
  output logic                      mbox_write,
  output logic                      mbox_read,
  input  wire logic [31:0]          mbox_rdata,
  // Memory controller configuration.
  input  wire logic [31:0]          channel0_dimm_config,
  input  wire logic [31:0]          channel1_dimm_config,
  // Display configuration status.
  input  wire logic                 any_interlaced,
  input  wire logic                 planes_tolerate_block,
  // Results to the watermark logic.
  output logic [8*9-1:0]            lat_adjusted,
  output logic [7:0]                lat_valid,
  output logic                      fetch_done,
  output logic                      fetch_error,
  output logic                      scaling_disable_needed,
  output logic                      agent_voltage_scaling,
  output logic                      dense_die_found,
  output logic                      irq
);

  typedef struct packed {
    dlf_pkg::dlf_state_t state;
    logic                second_set;
    logic [10:0]         timer;
    logic [31:0]         raw_low;
    logic [8*9-1:0]      lat;
    logic [7:0]          valid;
    logic                done;
    logic                error;
    logic [1:0]          irq_status;
    logic [1:0]          irq_mask;
    logic                scale_en;
    logic                scale_dis;
    logic [31:0]         rdata;
    logic [1:0]          maddr;
    logic [31:0]         mwdata;
    logic                mwrite;
    logic                mread;
  } dlf_regs_t;

  dlf_regs_t r;
  dlf_regs_t next_r;
  logic [3:0] slot_dense;
  logic       timed_out;
  logic       start;

  ////////////////////////////////////////////////////////////////////////////
  // Dense-die scan of both channels.

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_slot
      dlf_dense_check u_check (
        .slot_config ((g < 2) ?
                      channel0_dimm_config[(g % 2) * dlf_pkg::DIMM_SLOT_STRIDE +: 16] :
                      channel1_dimm_config[(g % 2) * dlf_pkg::DIMM_SLOT_STRIDE +: 16]),
        .dense_die   (slot_dense[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Latency unpacking and adjustment.

  // Builds the adjusted levels from both raw words; valid flags come from valid_levels.
  function automatic logic [8*9-1:0] adjust_levels(input logic [63:0] raw,
                                                   input logic dense);
    logic [8*9-1:0] out;
    logic [8:0]     lvl;
    out = '0;
    for (int i = 0; i < 8; i++) begin
      lvl = {1'b0, raw[i*8 +: 8]};
      if (raw[7:0] == 8'h00) begin
        lvl = lvl + dlf_pkg::READ_LAT_ADD_US;
      end
      if (i == 0 && dense) begin
        lvl = lvl + dlf_pkg::DENSE_ADD_US;
      end
      out[i*9 +: 9] = lvl;
    end
    return out;
  endfunction

  // Level 0 is always usable; a zero level ends the usable chain.
  function automatic logic [7:0] valid_levels(input logic [63:0] raw);
    logic [7:0] v;
    v    = '0;
    v[0] = 1'b1;
    for (int i = 1; i < 8; i++) begin
      // Zero invalidates upward; equal values pass.
      v[i] = v[i-1] && (raw[i*8 +: 8] != 8'h00);
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // The timer runs from each command so a stuck firmware cannot hang the fetch.
  always_comb begin
    next_r        = r;
    next_r.mwrite = 1'b0;
    next_r.mread  = 1'b0;
    next_r.rdata  = 32'h0000_0000;
    start         = reg_write && reg_addr == dlf_pkg::REG_CONTROL &&
                    reg_wdata[dlf_pkg::CTRL_START_BIT];
    timed_out     = r.timer == 11'h000;
    if (r.state != dlf_pkg::DLF_IDLE && !timed_out) begin
      next_r.timer = r.timer - 11'h001;
    end

    unique case (r.state)
      dlf_pkg::DLF_IDLE: begin
        if (start) begin
          next_r.second_set = 1'b0;
          next_r.done       = 1'b0;
          next_r.error      = 1'b0;
          next_r.valid      = 8'h00;
          next_r.timer      = dlf_pkg::QUERY_TIMEOUT_CYC[10:0];
          next_r.state      = dlf_pkg::DLF_CHECK;
        end
      end
      dlf_pkg::DLF_CHECK: begin
        next_r.maddr = dlf_pkg::MBOX_IFACE;
        next_r.mread = 1'b1;
        next_r.state = dlf_pkg::DLF_CHECK_WAIT;
      end
      dlf_pkg::DLF_CHECK_WAIT: begin
        // Wait for idle mailbox.
        // Mailbox data only stand the cycle after the read strobe.
        if (r.mread) begin
          next_r.state = dlf_pkg::DLF_CHECK_WAIT;
        end else if (!mbox_rdata[dlf_pkg::IFACE_PENDING_BIT]) begin
          next_r.state = dlf_pkg::DLF_WR_PRIMARY;
        end else if (timed_out) begin
          next_r.state = dlf_pkg::DLF_FINISH;
          next_r.error = 1'b1;
        end else begin
          next_r.state = dlf_pkg::DLF_CHECK;
        end
      end
      dlf_pkg::DLF_WR_PRIMARY: begin
        next_r.maddr  = dlf_pkg::MBOX_DATA_PRIMARY;
        next_r.mwdata = r.second_set ? dlf_pkg::SET_SECOND : dlf_pkg::SET_FIRST;
        next_r.mwrite = 1'b1;
        next_r.state  = dlf_pkg::DLF_WR_SECONDARY;
      end
      dlf_pkg::DLF_WR_SECONDARY: begin
        next_r.maddr  = dlf_pkg::MBOX_DATA_SECONDARY;
        next_r.mwdata = dlf_pkg::SECONDARY_ZERO;
        next_r.mwrite = 1'b1;
        next_r.state  = dlf_pkg::DLF_WR_IFACE;
      end
      dlf_pkg::DLF_WR_IFACE: begin
        next_r.maddr  = dlf_pkg::MBOX_IFACE;
        next_r.mwdata = dlf_pkg::IFACE_QUERY_WORD;
        next_r.mwrite = 1'b1;
        next_r.timer  = dlf_pkg::QUERY_TIMEOUT_CYC[10:0];
        next_r.state  = dlf_pkg::DLF_POLL;
      end
      dlf_pkg::DLF_POLL: begin
        next_r.maddr = dlf_pkg::MBOX_IFACE;
        next_r.mread = 1'b1;
        next_r.state = dlf_pkg::DLF_POLL_WAIT;
      end
      dlf_pkg::DLF_POLL_WAIT: begin
        // Success needs pending clear and code 00h.
        if (r.mread) begin
          next_r.state = dlf_pkg::DLF_POLL_WAIT;
        end else if (!mbox_rdata[dlf_pkg::IFACE_PENDING_BIT] &&
            mbox_rdata[7:0] == dlf_pkg::RESULT_SUCCESS) begin
          next_r.state = dlf_pkg::DLF_READ;
        end else if (timed_out) begin
          next_r.state = dlf_pkg::DLF_FINISH;
          next_r.error = 1'b1;
        end else begin
          next_r.state = dlf_pkg::DLF_POLL;
        end
      end
      dlf_pkg::DLF_READ: begin
        next_r.maddr = dlf_pkg::MBOX_DATA_PRIMARY;
        next_r.mread = 1'b1;
        next_r.state = dlf_pkg::DLF_READ_WAIT;
      end
      dlf_pkg::DLF_READ_WAIT: begin
        if (r.mread) begin
          next_r.state = dlf_pkg::DLF_READ_WAIT;
        end else if (!r.second_set) begin
          next_r.raw_low    = mbox_rdata;
          next_r.second_set = 1'b1;
          next_r.timer      = dlf_pkg::QUERY_TIMEOUT_CYC[10:0];
          next_r.state      = dlf_pkg::DLF_CHECK;
        end else begin
          next_r.lat   = adjust_levels({mbox_rdata, r.raw_low}, |slot_dense);
          next_r.valid = valid_levels({mbox_rdata, r.raw_low});
          next_r.done  = 1'b1;
          next_r.state = dlf_pkg::DLF_FINISH;
        end
      end
      dlf_pkg::DLF_FINISH: begin
        next_r.state = dlf_pkg::DLF_IDLE;
      end
      default: begin
        next_r.state = dlf_pkg::DLF_IDLE;
      end
    endcase

    next_r.scale_dis = any_interlaced || !planes_tolerate_block;

    // Interrupt status: a clear by write of one loses to a same-cycle event.
    if (reg_write && reg_addr == dlf_pkg::REG_IRQ_STATUS) begin
      next_r.irq_status = r.irq_status & ~reg_wdata[1:0];
    end
    if (reg_write && reg_addr == dlf_pkg::REG_IRQ_MASK) begin
      next_r.irq_mask = reg_wdata[1:0];
    end
    // Software records the scaling state once firmware has it.
    if (reg_write && reg_addr == dlf_pkg::REG_SCALING) begin
      next_r.scale_en = reg_wdata[dlf_pkg::SCALE_ENABLED_BIT];
    end
    if (r.state == dlf_pkg::DLF_FINISH) begin
      next_r.irq_status[dlf_pkg::IRQ_DONE_BIT]  = r.done | next_r.irq_status[0];
      next_r.irq_status[dlf_pkg::IRQ_ERROR_BIT] = r.error | next_r.irq_status[1];
    end

    // Register reads answer one cycle later; unmapped offsets read zero.
    if (reg_read) begin
      unique case (reg_addr)
        dlf_pkg::REG_STATUS: next_r.rdata = {27'h000_0000, dense_die_found, r.scale_dis,
                                             r.state != dlf_pkg::DLF_IDLE, r.error, r.done};
        dlf_pkg::REG_IRQ_STATUS: next_r.rdata = {30'h0000_0000, r.irq_status};
        dlf_pkg::REG_IRQ_MASK:   next_r.rdata = {30'h0000_0000, r.irq_mask};
        dlf_pkg::REG_LAT_LOW:    next_r.rdata = {r.lat[33:27], r.lat[24:18], r.lat[15:9],
                                                 r.lat[8:0]};
        dlf_pkg::REG_LAT_HIGH:   next_r.rdata = {r.lat[69:63], r.lat[60:54], r.lat[51:45],
                                                 r.lat[44:36]};
        dlf_pkg::REG_LAT_VALID:  next_r.rdata = {24'h00_0000, r.valid};
        dlf_pkg::REG_SCALING:    next_r.rdata = {31'h0000_0000, r.scale_en};
        default:                 next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clock) begin
    if (reset) begin
      r            <= '0;
      r.state      <= dlf_pkg::DLF_IDLE;
      r.irq_mask   <= dlf_pkg::IRQ_MASK_RESET;
      r.scale_en   <= dlf_pkg::SCALE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs.
  assign reg_rdata              = r.rdata;
  assign mbox_addr              = r.maddr;
  assign mbox_wdata             = r.mwdata;
  assign mbox_write             = r.mwrite;
  assign mbox_read              = r.mread;
  assign lat_adjusted           = r.lat;
  assign lat_valid              = r.valid;
  assign fetch_done             = r.done;
  assign fetch_error            = r.error;
  assign scaling_disable_needed = r.scale_dis;
  assign agent_voltage_scaling  = r.scale_en;
  assign dense_die_found        = |slot_dense;
  assign irq                    = |(r.irq_status & ~r.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // Cycles spent polling one query; too long for a delay range.
  logic [10:0] poll_age;
  always_ff @(posedge clock) begin
    if (reset || !(r.state == dlf_pkg::DLF_POLL || r.state == dlf_pkg::DLF_POLL_WAIT)) begin
      poll_age <= 11'h000;
    end else begin
      poll_age <= poll_age + 11'h001;
    end
  end

  property p_iface_word;
    @(posedge clock) disable iff (reset)
      (mbox_write && mbox_addr == dlf_pkg::MBOX_IFACE) |-> mbox_wdata == 32'h8000_0006;
  endproperty
  a_iface_word: assert property (p_iface_word) else $error("bad query word");

  property p_secondary_zero;
    @(posedge clock) disable iff (reset)
      (mbox_write && mbox_addr == dlf_pkg::MBOX_DATA_SECONDARY) |-> mbox_wdata == 32'h0;
  endproperty
  a_secondary_zero: assert property (p_secondary_zero) else $error("secondary not zero");

  property p_primary_order;
    @(posedge clock) disable iff (reset)
      (mbox_write && mbox_addr == dlf_pkg::MBOX_DATA_PRIMARY) |->
        ##1 (mbox_write && mbox_addr == dlf_pkg::MBOX_DATA_SECONDARY)
        ##1 (mbox_write && mbox_addr == dlf_pkg::MBOX_IFACE);
  endproperty
  a_primary_order: assert property (p_primary_order) else $error("bad write order");

  property p_check_first;
    @(posedge clock) disable iff (reset)
      $rose(mbox_write && mbox_addr == dlf_pkg::MBOX_DATA_PRIMARY) |->
        $past(mbox_rdata[31], 2) == 1'b0;
  endproperty
  a_check_first: assert property (p_check_first) else $error("mailbox still busy");

  property p_timeout_bound;
    @(posedge clock) disable iff (reset)
      (r.state == dlf_pkg::DLF_POLL || r.state == dlf_pkg::DLF_POLL_WAIT) |->
        poll_age < 11'h3EC;
  endproperty
  a_timeout_bound: assert property (p_timeout_bound) else $error("query overran timeout");

  property p_valid_chain;
    @(posedge clock) disable iff (reset)
      (lat_valid[7:1] & ~lat_valid[6:0]) == 7'h00;
  endproperty
  a_valid_chain: assert property (p_valid_chain) else $error("valid chain broken");

  property p_done_publish;
    @(posedge clock) disable iff (reset)
      $rose(fetch_done) |-> lat_valid[0] && !fetch_error && $past(mbox_read, 2);
  endproperty
  a_done_publish: assert property (p_done_publish) else $error("done without data");

  property p_irq_event;
    @(posedge clock) disable iff (reset)
      (r.state == dlf_pkg::DLF_FINISH && fetch_error) |=> r.irq_status[1];
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("error event lost");

  property p_scale_decision;
    @(posedge clock) disable iff (reset)
      any_interlaced |=> scaling_disable_needed;
  endproperty
  a_scale_decision: assert property (p_scale_decision) else $error("scaling not disabled");

endmodule // dlf_latency_fetch

// ---- rtl/dlf_pkg.sv ----
// Constants, register map and state types for the display latency fetch block.
package dlf_pkg;

  // Clock rate and timing.
  localparam int unsigned CLOCK_MHZ          = 10;
  localparam int unsigned QUERY_TIMEOUT_US   = 100;
  localparam int unsigned QUERY_TIMEOUT_CYC  = QUERY_TIMEOUT_US * CLOCK_MHZ;
  localparam int unsigned BLOCK_TIME_US      = 10;
  localparam int unsigned TIMER_W            = 11;

  // Latency adjustments in microseconds.
  localparam logic [8:0] READ_LAT_ADD_US     = 9'h002;
  localparam logic [8:0] DENSE_ADD_US        = 9'h001;
  localparam int unsigned NUM_LEVELS         = 8;
  localparam int unsigned LAT_W              = 9;

  // Mailbox word selects on the mailbox master port.
  localparam logic [1:0] MBOX_IFACE          = 2'h0;
  localparam logic [1:0] MBOX_DATA_PRIMARY   = 2'h1;
  localparam logic [1:0] MBOX_DATA_SECONDARY = 2'h2;

  // Mailbox interface word layout.
  localparam int unsigned IFACE_PENDING_BIT  = 31;
  localparam logic [7:0]  CMD_LATENCY_QUERY  = 8'h06;
  localparam logic [7:0]  RESULT_SUCCESS     = 8'h00;
  localparam logic [31:0] IFACE_QUERY_WORD   = 32'h8000_0006;
  localparam logic [31:0] SET_FIRST          = 32'h0000_0000;
  localparam logic [31:0] SET_SECOND         = 32'h0000_0001;
  localparam logic [31:0] SECONDARY_ZERO     = 32'h0000_0000;

  // Memory controller DIMM config field layout (per DIMM slot).
  localparam int unsigned DIMM_SLOT_STRIDE   = 16;
  localparam int unsigned MODULE_CAPACITY_LSB      = 0;
  localparam int unsigned DIMM_WIDTH_BIT     = 8;
  localparam int unsigned DIMM_RANKS_BIT     = 10;
  localparam logic [7:0]  SIZE_8GB           = 8'h08;
  localparam logic [7:0]  SIZE_16GB          = 8'h10;
  localparam logic [7:0]  SIZE_32GB          = 8'h20;

  // Register offsets.
  localparam logic [4:0] REG_CONTROL         = 5'h00;
  localparam logic [4:0] REG_STATUS          = 5'h04;
  localparam logic [4:0] REG_IRQ_STATUS      = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK        = 5'h0C;
  localparam logic [4:0] REG_LAT_LOW         = 5'h10;
  localparam logic [4:0] REG_LAT_HIGH        = 5'h14;
  localparam logic [4:0] REG_LAT_VALID       = 5'h18;
  localparam logic [4:0] REG_SCALING         = 5'h1C;

  // Field positions and reset values.
  localparam int unsigned CTRL_START_BIT     = 0;
  localparam int unsigned IRQ_DONE_BIT       = 0;
  localparam int unsigned IRQ_ERROR_BIT      = 1;
  localparam int unsigned SCALE_ENABLED_BIT  = 0;
  localparam logic [1:0]  IRQ_MASK_RESET     = 2'h0;
  localparam logic        SCALE_RESET        = 1'b1;

  // Fetch sequence states.
  typedef enum logic [3:0] {
    DLF_IDLE, DLF_CHECK, DLF_CHECK_WAIT, DLF_WR_PRIMARY, DLF_WR_SECONDARY,
    DLF_WR_IFACE, DLF_POLL, DLF_POLL_WAIT, DLF_READ, DLF_READ_WAIT, DLF_FINISH
  } dlf_state_t;

endpackage : dlf_pkg

// ---- rtl/dlf_dense_check.sv ----
// Dense-die classifier for one DIMM slot of a memory channel config word.
module dlf_dense_check (
  // Slot configuration.
  input  wire logic [15:0] slot_config,
  // Classification.
  output logic             dense_die
);

  logic [7:0] module_capacity;
  logic       width16;
  logic       two_ranks;

  // An empty slot (zero size) never counts.
  always_comb begin
    module_capacity = slot_config[dlf_pkg::MODULE_CAPACITY_LSB +: 8];
    width16         = slot_config[dlf_pkg::DIMM_WIDTH_BIT];
    two_ranks       = slot_config[dlf_pkg::DIMM_RANKS_BIT];
    dense_die = (module_capacity != 8'h00) &&
      ((!two_ranks && !width16 && module_capacity == dlf_pkg::SIZE_16GB) ||
       ( two_ranks && !width16 && module_capacity == dlf_pkg::SIZE_32GB) ||
       (!two_ranks &&  width16 && module_capacity == dlf_pkg::SIZE_8GB)  ||
       ( two_ranks &&  width16 && module_capacity == dlf_pkg::SIZE_16GB));
  end

endmodule // dlf_dense_check

// ---- testbench/dlf_mbox_model.sv ----
// Behavioural firmware command mailbox that answers the latency fetch block.
module dlf_mbox_model (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Mailbox slave port.
  input  wire logic [1:0]  mbox_addr,
  input  wire logic [31:0] mbox_wdata,
  input  wire logic        mbox_write,
  input  wire logic        mbox_read,
  output logic      [31:0] mbox_rdata,
  // Scenario controls.
  input  wire logic [31:0] set_first,
  input  wire logic [31:0] set_second,
  input  wire logic [15:0] delay,
  input  wire logic [7:0]  result_code,
  input  wire logic        prebusy,
  output int               proto_errs
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] iface;
  logic [31:0] primary;
  logic [31:0] secondary;
  logic [31:0] rd_word;
  logic [31:0] last;
  logic [15:0] cnt;
  logic        rd_pend;
  logic        is_query;
  logic        nq;
  logic        bad;

  ////////////////////////////////////////////////////////////////////////////
  // requester checks
  always_comb begin
    bad = mbox_write && (iface[31] || (mbox_addr == 2'h0 && (mbox_wdata !== 32'h8000_0006
          || secondary !== 32'h0000_0000 || primary !== {31'h0000_0000, nq})));
  end

  // Read data stand one cycle only; outside it the port shows the inverse of the
  // last word, so a design that samples late never sees a lucky value.
  assign mbox_rdata = rd_pend ? rd_word : ~last;

  // Mailbox state; a query completes after the programmed delay.
  always_ff @(posedge clock) begin
    rd_pend <= mbox_read && !reset;
    if (rd_pend) begin
      last <= mbox_rdata;
    end
    if (reset) begin
      iface      <= 32'h0000_0000;
      primary    <= 32'h0000_0000;
      secondary  <= 32'h0000_0000;
      last       <= 32'h0000_0000;
      cnt        <= 16'h0000;
      is_query   <= 1'b0;
      nq         <= 1'b0;
      proto_errs <= 0;
    end else begin
      if (bad) begin
        proto_errs <= proto_errs + 1;
      end
      if (mbox_read) begin
        rd_word <= (mbox_addr == 2'h0) ? iface : (mbox_addr == 2'h1) ? primary : secondary;
      end
      if (mbox_write) begin
        case (mbox_addr)
          2'h1: primary <= mbox_wdata;
          2'h2: secondary <= mbox_wdata;
          default: begin
            iface    <= mbox_wdata;
            cnt      <= delay;
            is_query <= 1'b1;
            nq       <= ~nq;
          end
        endcase
      end else if (prebusy) begin
        iface    <= 32'h8000_0000;
        cnt      <= delay;
        is_query <= 1'b0;
      end else if (iface[31]) begin
        if (cnt != 16'h0000) begin
          cnt <= cnt - 16'h0001;
        end else begin
          iface <= {24'h00_0000, result_code};
          if (is_query) begin
            primary <= primary[0] ? set_second : set_first;
          end
        end
      end
    end
  end
endmodule // dlf_mbox_model

// ---- testbench/tb.sv ----
// Self-checking testbench for the display latency fetch block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mbox_wdata, mbox_rdata, d;
  logic        clock, reset, reg_write, reg_read, mbox_write, mbox_read, irq;
  logic [1:0]  mbox_addr;
  logic [31:0] channel0_dimm_config, channel1_dimm_config, set_first, set_second;
  logic        any_interlaced, planes_tolerate_block, fetch_done, fetch_error, prebusy;
  logic [71:0] lat_adjusted;
  logic [7:0]  lat_valid, result_code;
  logic        scaling_disable_needed, agent_voltage_scaling, dense_die_found;
  logic [15:0] delay;
  logic [15:0] slot_tbl [6] = '{16'h0010, 16'h0420, 16'h0108, 16'h0510, 16'h0410, 16'h0000};
  logic [5:0]  dense_tbl = 6'b00_1111;
  int          err_total = 0, total_checks = 0, cyc = 0, proto_errs, k;

  dlf_latency_fetch i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mbox_addr(mbox_addr), .mbox_wdata(mbox_wdata), .mbox_write(mbox_write),
    .mbox_read(mbox_read), .mbox_rdata(mbox_rdata),
    .channel0_dimm_config(channel0_dimm_config), .channel1_dimm_config(channel1_dimm_config),
    .any_interlaced(any_interlaced), .planes_tolerate_block(planes_tolerate_block),
    .lat_adjusted(lat_adjusted), .lat_valid(lat_valid), .fetch_done(fetch_done),
    .fetch_error(fetch_error), .scaling_disable_needed(scaling_disable_needed),
    .agent_voltage_scaling(agent_voltage_scaling), .dense_die_found(dense_die_found),
    .irq(irq));

  dlf_mbox_model i_fw (.clock(clock), .reset(reset), .mbox_addr(mbox_addr),
    .mbox_wdata(mbox_wdata), .mbox_write(mbox_write), .mbox_read(mbox_read),
    .mbox_rdata(mbox_rdata), .set_first(set_first), .set_second(set_second), .delay(delay),
    .result_code(result_code), .prebusy(prebusy), .proto_errs(proto_errs));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Watchdog: the whole sequence needs a few thousand cycles at most.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("wrong value at %0t ns: run did not finish", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and register bus tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
      err_total++;
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(negedge clock);
  endtask

  // Read data are only valid in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask

  // Runs one fetch and checks the levels against values worked out here.
  task automatic fetch(input logic dense, input logic exp_err);
    logic [7:0]  raw;
    logic [8:0]  e;
    logic [7:0]  vexp;
    logic        ok;
    int          n;
    wr(dlf_pkg::REG_CONTROL, 32'h0000_0001);
    n = 0;
    while (fetch_done !== 1'b1 && fetch_error !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk({30'h0, fetch_error, fetch_done}, exp_err ? 32'h2 : 32'h1, "completion");
    if (exp_err) chk(32'(n >= dlf_pkg::QUERY_TIMEOUT_CYC && n < 1100), 32'h1, "span");
    ok = 1'b1;
    vexp = 8'h00;
    for (int i = 0; i < 8; i++) begin
      raw = (i < 4) ? set_first[i*8 +: 8] : set_second[(i-4)*8 +: 8];
      if (i > 0 && raw == 8'h00) ok = 1'b0;
      e = {1'b0, raw} + ((set_first[7:0] == 8'h00) ? 9'h002 : 9'h000) + ((i == 0 && dense) ? 9'h001 : 9'h000);
      if (ok && !exp_err) begin
        vexp[i] = 1'b1;
        chk(32'(lat_adjusted[i*9 +: 9]), 32'(e), "level");
      end
    end
    chk(32'(lat_valid), 32'(vexp), "valid flags");
    rd(dlf_pkg::REG_STATUS, d);
    chk(d & 32'h0000_0007, exp_err ? 32'h2 : 32'h1, "status");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {reset, reg_write, reg_read, any_interlaced, prebusy} = 5'b1_0000;
    {reg_addr, reg_wdata, channel0_dimm_config, channel1_dimm_config} = '0;
    {set_first, set_second, result_code} = '0;
    planes_tolerate_block = 1'b1;
    delay = 16'h0004;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd(dlf_pkg::REG_SCALING, d);
    chk(d, 32'h0000_0001, "scaling reset");
    chk(32'(agent_voltage_scaling), 32'h1, "scaling pin");
    rd(dlf_pkg::REG_IRQ_MASK, d);
    chk(d, 32'h0000_0000, "mask reset");
    wr(5'h1E, 32'hFFFF_FFFF);
    rd(5'h1E, d);
    chk(d, 32'h0000_0000, "unmapped");
    // Every combination of interlace and block tolerance.
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      any_interlaced        <= k[0];
      planes_tolerate_block <= k[1];
      @(posedge clock);
      @(negedge clock);
      chk(32'(scaling_disable_needed), 32'(k[0] | !k[1]), "scale disable");
    end
    // Dense cases placed in the second slot of the second channel.
    for (k = 0; k < 6; k++) begin
      @(posedge clock);
      channel1_dimm_config <= {slot_tbl[k], 16'h0000};
      @(negedge clock);
      chk(32'(dense_die_found), 32'(dense_tbl[k]), "dense class");
    end
    // Slow fetch behind a busy mailbox, zero level 0, dense DIMM, equal neighbours.
    @(posedge clock);
    channel0_dimm_config <= 32'h0000_0010;
    set_first            <= 32'h0A0A_0500;
    set_second           <= 32'h0014_120C;
    delay                <= 16'h0032;
    prebusy              <= 1'b1;
    @(posedge clock);
    prebusy <= 1'b0;
    fetch(1'b1, 1'b0);
    rd(dlf_pkg::REG_LAT_VALID, d);
    chk(d, 32'h0000_007F, "valid register");
    chk(32'(irq), 32'h1, "irq raised");
    wr(dlf_pkg::REG_IRQ_MASK, 32'h0000_0003);
    chk(32'(irq), 32'h0, "irq masked");
    wr(dlf_pkg::REG_IRQ_MASK, 32'h0000_0000);
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(dlf_pkg::REG_IRQ_STATUS, 32'h0000_0001);
    rd(dlf_pkg::REG_IRQ_STATUS, d);
    chk(d | {31'h0, irq}, 32'h0, "irq cleared");
    wr(dlf_pkg::REG_SCALING, 32'h0000_0000);
    chk(32'(agent_voltage_scaling), 32'h0, "scaling off");
    // Prompt fetch with level 1 empty, no dense DIMM.
    @(posedge clock);
    channel0_dimm_config <= 32'h0000_0000;
    set_first            <= 32'h0908_0005;
    delay                <= 16'h0000;
    fetch(1'b0, 1'b0);
    wr(dlf_pkg::REG_IRQ_STATUS, 32'h0000_0003);
    // Failing result code must end in a timeout with no valid level.
    @(posedge clock);
    result_code <= 8'h01;
    fetch(1'b0, 1'b1);
    rd(dlf_pkg::REG_IRQ_STATUS, d);
    chk(d, 32'h0000_0002, "error event");
    chk(32'(proto_errs), 32'h0, "mailbox protocol");
    results();
  end
endmodule // tb
